/* File: core/ccr_clock_reset.sv */
// core clock ratio select, reset sequence and reset complete output
// assumes board drives ratio select constant and loops reset done to mem por
// every output is registered and all enables stay low while reset is held
`timescale 1ns/1ps
`default_nettype none
`include "ccr_params.svh"
module ccr_clock_reset
  import ccr_pkg::*;
#(
  parameter int SEQ_CYCLES = `CCR_SEQ_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_core_ratio_select,
  input  wire logic       i_mem_por,
  output logic [3:0]      o_core_ratio,
  output logic            o_ratio_reserved,
  output logic            o_instr_strobe,
  output logic            o_cluster_tick,
  output logic            o_exec_idle,
  output logic            o_mem_reset,
  output logic            o_rst_done,
  output logic            o_rst_done_oe,
  output logic            o_pins_oe
);
  // mapping of ratio select to multiplier
  function automatic ccr_ratio_s decode_ratio(input logic [2:0] sel);
    ccr_ratio_s r;
    r = '{ratio: `CCR_RATIO_RESET, reserved: 1'b0};
    unique case (sel)
      3'h0: r.ratio = 4'h4;
      3'h1: r.ratio = 4'h5;
      3'h2: r.ratio = 4'h6;
      3'h3: r.ratio = 4'h7;
      3'h4: r.ratio = 4'h8;
      3'h5: r.ratio = 4'ha;
      3'h6: r.ratio = 4'hc;
      3'h7: r.reserved = 1'b1;
    endcase
    return r;
  endfunction

  // synchroniser depth; the memory reset output follows its pin three edges later
  localparam int SYNC_STAGES = 2;

  // synchroniser chain: bit 0 takes the pin and only the top bit is read
  logic [SYNC_STAGES-1:0] por_sync_r;
  logic [SYNC_STAGES-1:0] por_sync_nxt;

  // reset sequencer state, latched strap and cycle count
  ccr_state_e             state_r;
  ccr_state_e             state_nxt;
  logic [2:0]             sel_r;
  logic [2:0]             sel_nxt;
  logic [15:0]            cnt_r;
  logic [15:0]            cnt_nxt;
  logic                   seq_end;

  // instruction strobe phase and the decoded ratio it counts to
  logic [3:0]             phase_r;
  logic [3:0]             phase_nxt;
  ccr_ratio_s             dec;

  // next values of the registered outputs
  ccr_ratio_s             dec_nxt;
  logic [3:0]             ratio_nxt;
  logic                   reserved_nxt;
  logic                   strobe_nxt;
  logic                   done_nxt;
  logic                   idle_nxt;
  logic                   tick_nxt;
  logic                   mem_reset_nxt;
  logic                   done_oe_nxt;
  logic                   pins_oe_nxt;

  // shift the pin up the chain; each stage but the top is read only by the next one
  always_comb begin
    por_sync_nxt = {por_sync_r[SYNC_STAGES-2:0], i_mem_por};
  end

  // synchroniser flops clear low, so memory stays in reset across release
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      por_sync_r <= {SYNC_STAGES{1'b0}};
    end else begin
      por_sync_r <= por_sync_nxt;
    end
  end

  // sequencer: latch strap on the first edge out of reset, count, then stay done
  always_comb begin
    // hold everything by default
    state_nxt = state_r;
    sel_nxt   = sel_r;
    cnt_nxt   = cnt_r;
    seq_end   = (cnt_r == 16'(SEQ_CYCLES - 1));
    unique case (state_r)
      CCR_ST_RESET: begin
        sel_nxt   = i_core_ratio_select;
        state_nxt = CCR_ST_SEQ;
        cnt_nxt   = 16'h0;
      end
      CCR_ST_SEQ: begin
        if (seq_end) begin
          state_nxt = CCR_ST_DONE;
        end else begin
          cnt_nxt = cnt_r + 16'h1;
        end
      end
      CCR_ST_DONE: begin
        state_nxt = CCR_ST_DONE; // strap changes are ignored until the next reset
      end
      default: begin
        state_nxt = CCR_ST_RESET;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // known state with execution parked, default strap
      state_r <= CCR_ST_RESET;
      sel_r   <= `CCR_SEL_RESET;
      cnt_r   <= 16'h0;
    end else begin
      state_r <= state_nxt;
      sel_r   <= sel_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // one strobe every ratio system clocks once done; none for the reserved code
  always_comb begin
    // hold the phase unless counting
    phase_nxt  = phase_r;
    strobe_nxt = 1'b0;
    dec        = decode_ratio(sel_r);
    if (state_r == CCR_ST_DONE && !dec.reserved) begin
      if (phase_r == dec.ratio - 4'h1) begin
        phase_nxt  = 4'h0;
        strobe_nxt = 1'b1;
      end else begin
        phase_nxt = phase_r + 4'h1;
      end
    end
  end

  // strobe phase register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_r <= 4'h0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ratio outputs decode the strap value being latched, so they show it at once
  always_comb begin
    dec_nxt      = decode_ratio(sel_nxt);
    ratio_nxt    = dec_nxt.ratio;
    reserved_nxt = dec_nxt.reserved;
  end

  // ratio output registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // default ratio until a strap is latched
      o_core_ratio     <= `CCR_RATIO_RESET;
      o_ratio_reserved <= 1'b0;
    end else begin
      // register the next values
      o_core_ratio     <= ratio_nxt;
      o_ratio_reserved <= reserved_nxt;
    end
  end

  // status outputs: done and idle are complements, both follow the next state
  always_comb begin
    done_nxt = (state_nxt == CCR_ST_DONE);
    idle_nxt = ~done_nxt;
  end

  // status output registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // execution idle, no strobe, sequence not complete
      o_instr_strobe <= 1'b0;
      o_exec_idle    <= 1'b1;
      o_rst_done     <= 1'b0;
    end else begin
      // register the next values
      o_instr_strobe <= strobe_nxt;
      o_exec_idle    <= idle_nxt;
      o_rst_done     <= done_nxt;
    end
  end

  // pin side outputs: cluster bus ticks on every system clock, drivers enabled
  always_comb begin
    tick_nxt      = 1'b1;
    mem_reset_nxt = ~por_sync_r[SYNC_STAGES-1];
    done_oe_nxt   = 1'b1;
    pins_oe_nxt   = 1'b1;
  end

  // pin side output registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // drivers released and memory held in reset while reset is applied
      o_cluster_tick <= 1'b0;
      o_mem_reset    <= 1'b1;
      o_rst_done_oe  <= 1'b0;
      o_pins_oe      <= 1'b0;
    end else begin
      // register the next values
      o_cluster_tick <= tick_nxt;
      o_mem_reset    <= mem_reset_nxt;
      o_rst_done_oe  <= done_oe_nxt;
      o_pins_oe      <= pins_oe_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: core/ccr_params.svh */
// constants for the core clock ratio and reset pin block
// assumes one 200 MHz system clock and an active high asynchronous reset
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH
`define CCR_SEL_RESET       3'h0
`define CCR_RATIO_RESET     4'h4
`define CCR_SEQ_TIME_NS     100
`define CCR_CLK_PERIOD_NS   5
`define CCR_SEQ_CYCLES      ((`CCR_SEQ_TIME_NS + `CCR_CLK_PERIOD_NS - 1) / `CCR_CLK_PERIOD_NS)
`endif

/* File: core/ccr_pkg.sv */
// types for the core clock ratio and reset pin block
// assumes nothing beyond the params header
`default_nettype none
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_ST_RESET = 2'b00,
    CCR_ST_SEQ   = 2'b01,
    CCR_ST_DONE  = 2'b10
  } ccr_state_e;
  typedef struct packed {
    logic [3:0] ratio;
    logic       reserved;
  } ccr_ratio_s;
endpackage
`default_nettype wire

/* File: verif/ccr_clock_reset_assertions.sv */
// checker for the clock ratio and reset pins block
// assumes it is bound to ccr_clock_reset and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ccr_clock_reset_chk #(
  parameter int SEQ_CYCLES = 20
) (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [2:0] i_core_ratio_select,
  input wire logic       i_mem_por,
  input wire logic [3:0] o_core_ratio,
  input wire logic       o_ratio_reserved,
  input wire logic       o_instr_strobe,
  input wire logic       o_cluster_tick,
  input wire logic       o_exec_idle,
  input wire logic       o_mem_reset,
  input wire logic       o_rst_done,
  input wire logic       o_rst_done_oe,
  input wire logic       o_pins_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [3:0] gap_r;
  // cycles since done or since the last instruction strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) gap_r <= 4'h0;
    else gap_r <= !o_rst_done ? 4'h0 : o_instr_strobe ? 4'h1 : gap_r + 4'h1;
  end
  property p_oe; !$past(i_rst) |-> o_pins_oe && o_rst_done_oe; endproperty
  a_oe: assert property (p_oe) else $error("output enable low after reset");
  property p_dec; $rose(o_pins_oe) |-> o_ratio_reserved == ($past(i_core_ratio_select) == 3'h7)
    && o_core_ratio == ($past(i_core_ratio_select) == 3'h5 ? 4'ha : $past(i_core_ratio_select)
    == 3'h6 ? 4'hc : $past(i_core_ratio_select) == 3'h7 ? 4'h4
    : {1'b0, $past(i_core_ratio_select)} + 4'h4); endproperty
  a_dec: assert property (p_dec) else $error("ratio decode wrong");
  property p_hold; o_pins_oe |=> $stable(o_core_ratio) && $stable(o_ratio_reserved); endproperty
  a_hold: assert property (p_hold) else $error("ratio changed after latch");
  property p_done; $rose(o_pins_oe) |-> !o_rst_done ##SEQ_CYCLES o_rst_done; endproperty
  a_done: assert property (p_done) else $error("reset done timing wrong");
  property p_done_at; $rose(o_rst_done) |-> $past(o_pins_oe, SEQ_CYCLES)
    && !$past(o_pins_oe, SEQ_CYCLES + 1); endproperty
  a_done_at: assert property (p_done_at) else $error("reset done too early or late");
  property p_idle; o_exec_idle != o_rst_done; endproperty
  a_idle: assert property (p_idle) else $error("idle and done disagree");
  property p_strb; o_rst_done |-> o_instr_strobe == (gap_r == o_core_ratio && !o_ratio_reserved);
  endproperty
  a_strb: assert property (p_strb) else $error("strobe spacing wrong");
  property p_tick; o_pins_oe |-> o_cluster_tick; endproperty
  a_tick: assert property (p_tick) else $error("cluster tick missing");
  property p_mem; o_pins_oe && $past(o_pins_oe, 3) |-> o_mem_reset == !$past(i_mem_por, 3);
  endproperty
  a_mem: assert property (p_mem) else $error("memory reset not synchronised");
  c_done: cover property ($rose(o_rst_done));
  c_strb: cover property (o_instr_strobe);
  c_rsv: cover property (o_rst_done && o_ratio_reserved);
endmodule
bind ccr_clock_reset ccr_clock_reset_chk #(.SEQ_CYCLES(SEQ_CYCLES)) chk_inst (.i_clk, .i_rst,
  .i_mem_por, .o_ratio_reserved, .o_instr_strobe, .o_cluster_tick, .o_exec_idle, .o_mem_reset,
  .o_rst_done, .o_rst_done_oe, .o_pins_oe, .i_core_ratio_select, .o_core_ratio);
`default_nettype wire

/* File: verif/ccr_board.sv */
// board model: reset done pin looped to memory power-on reset
// assumes the released pin is pulled low, holding memory in reset
`timescale 1ns/1ps
`default_nettype none
module ccr_board (
  input  wire logic i_done,
  input  wire logic i_done_oe,
  input  wire logic i_hold,
  output logic      o_por
);
  // loopback; i_hold lets the bench keep memory in reset
  assign o_por = i_done_oe & i_done & ~i_hold;
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// bench: strap sweep plus random straps, reset, strobe counts
// assumes the board model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clk = 0, i_rst = 1, por, hold = 0, rsv, strb, tick, idle, memr, done, done_oe, oe;
  logic [2:0] sel = 3'h0, s;
  logic [3:0] ratio;
  logic [31:0] seed = 32'h80675300;
  int errors = 0, checks = 0;
  logic [7:0] n;
  ccr_clock_reset #(.SEQ_CYCLES(2)) ccr_clock_reset_inst (.i_clk, .i_rst,
    .i_core_ratio_select(sel), .i_mem_por(por), .o_core_ratio(ratio), .o_ratio_reserved(rsv),
    .o_instr_strobe(strb), .o_cluster_tick(tick), .o_exec_idle(idle), .o_mem_reset(memr),
    .o_rst_done(done), .o_rst_done_oe(done_oe), .o_pins_oe(oe));
  ccr_board ccr_board_inst (.i_done(done), .i_done_oe(done_oe), .i_hold(hold), .o_por(por));
  function automatic logic [3:0] exp_ratio(input logic [2:0] v);
    return v == 3'h5 ? 4'ha : v == 3'h6 ? 4'hc : v == 3'h7 ? 4'h4 : {1'b0, v} + 4'h4;
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial forever #2.5 i_clk = ~i_clk;
  initial begin
    #50us;
    errors++;
    complete_run();
  end
  // every strap code, then random ones; strap flipped after latch
  initial begin
    for (int i = 0; i < 16; i++) begin
      @(negedge i_clk);
      seed = xs(seed);
      s = i < 8 ? i[2:0] : seed[2:0];
      i_rst = 1;
      sel = s;
      hold = seed[3];
      repeat (4) @(negedge i_clk);
      cmp({oe, done_oe, done, idle, memr}, 8'h03);
      i_rst = 0;
      repeat (2) @(negedge i_clk);
      cmp({oe, done_oe, tick, idle, memr}, 8'h1f);
      sel = ~s;
      for (n = 0; n < 20 && !done; n++) @(negedge i_clk);
      cmp({done, rsv, ratio}, {1'b1, s == 3'h7, exp_ratio(s)});
      n = 0;
      repeat (120) begin
        @(negedge i_clk);
        n += strb;
      end
      cmp(n[7:0], s == 3'h7 ? 8'h00 : 8'h78 / exp_ratio(s));
      cmp({tick, idle, memr}, {2'b10, hold});
    end
    complete_run();
  end
endmodule
`default_nettype wire
